// >>> rtl/ddswd_decoder.sv
`include "ddswd_defs.svh"

module ddswd_decoder #(
    parameter int FIFO_DEPTH = `DDSWD_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic update_hold,
    output logic [`DDSWD_DATA_BITS-1:0] channel_a_output,
    output logic [`DDSWD_DATA_BITS-1:0] channel_b_output,
    output logic [`DDSWD_DATA_BITS-1:0] buffer_value,
    output logic speed_select_bit,
    output logic power_down_flag,
    output logic word_dropped
);
    logic [2:0] pins_sync;
    logic cs_n_s;
    logic sclk_s;
    logic din_s;
    logic sclk_prev_q;
    logic cs_n_prev_q;
    logic sclk_fall;
    logic sclk_rise;
    logic cs_rise;
    ddswd_pkg::ddswd_shift_type state_q;
    logic [`DDSWD_CNT_BITS-1:0] count_q;
    logic [`DDSWD_WORD_BITS-1:0] shift_q;
    logic push_valid;
    logic push_ready;
    logic pop_valid;
    logic pop_ready;
    logic [`DDSWD_WORD_BITS-1:0] pop_word;
    logic take;
    ddswd_pkg::ddswd_sel_type sel;
    logic [`DDSWD_DATA_BITS-1:0] new_data;
    logic [`DDSWD_DATA_BITS-1:0] chan_a_q;
    logic [`DDSWD_DATA_BITS-1:0] chan_b_q;
    logic [`DDSWD_DATA_BITS-1:0] buf_q;
    logic speed_q;
    logic pdown_q;
    logic dropped_q;

    // pins come from the host's domain, so all three pass two flops
    ddswd_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({chip_select_n, serial_clock, serial_data}),
        .sync_out(pins_sync)
    );

    assign cs_n_s = pins_sync[2];
    assign sclk_s = pins_sync[1];
    assign din_s = pins_sync[0];

    // edge history of the synchronised pins
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sclk_prev_q <= 1'h1;
            cs_n_prev_q <= 1'h1;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            cs_n_prev_q <= cs_n_s;
        end
    end

    // data and clock share the sync delay, so data is sampled at the fall it belongs to
    assign sclk_fall = sclk_prev_q && !sclk_s;
    assign sclk_rise = !sclk_prev_q && sclk_s;
    assign cs_rise = !cs_n_prev_q && cs_n_s;

    // shifter: msb first on falling edges while selected
    // shift_q is kept across frames, so a cut word carries older bits above the new ones
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_q <= ddswd_pkg::SH_IDLE;
            count_q <= '0;
            shift_q <= '0;
        end
        else if (cs_n_s)
        begin
            state_q <= ddswd_pkg::SH_IDLE;
            count_q <= '0;
        end
        else
        begin
            case (state_q)
                ddswd_pkg::SH_IDLE,
                ddswd_pkg::SH_SHIFT:
                begin
                    if (sclk_fall)
                    begin
                        shift_q <= {shift_q[`DDSWD_WORD_BITS-2:0], din_s}; // RULE1
                        count_q <= count_q + 1'h1;
                        if (count_q == `DDSWD_LAST_BIT)
                            state_q <= ddswd_pkg::SH_DONE; // RULE2
                        else
                            state_q <= ddswd_pkg::SH_SHIFT;
                    end
                end
                ddswd_pkg::SH_DONE:
                begin
                    // a second word may follow under the same select
                    if (sclk_rise)
                    begin
                        state_q <= ddswd_pkg::SH_IDLE;
                        count_q <= '0;
                    end
                end
                default:
                begin
                    state_q <= ddswd_pkg::SH_IDLE;
                    count_q <= '0;
                end
            endcase
        end
    end

    // hand the word on at the rise after bit 0, or at an early deselect
    assign push_valid = ((state_q == ddswd_pkg::SH_DONE) && sclk_rise && !cs_n_s) // RULE14
        || (cs_rise && (state_q != ddswd_pkg::SH_IDLE)); // RULE2

    // the host cannot be stalled, so a word meeting a full fifo is lost and flagged
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            dropped_q <= 1'h0;
        else
            dropped_q <= push_valid && !push_ready;
    end

    ddswd_fifo #(
        .WIDTH(`DDSWD_WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(shift_q),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_word)
    );

    // hold lets the system freeze updates; words queue up meanwhile
    assign pop_ready = !update_hold;
    assign take = pop_valid && pop_ready;

    // word fields
    assign sel = ddswd_pkg::ddswd_sel_type'({pop_word[`DDSWD_SEL_HI_POS],
        pop_word[`DDSWD_SEL_LO_POS]}); // RULE4
    assign new_data = pop_word[`DDSWD_DATA_MSB:0]; // RULE12

    // mode bits: power-down overrides the whole word
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            speed_q <= `DDSWD_SPEED_RST; // RULE7
            pdown_q <= `DDSWD_PDOWN_RST; // RULE7
        end
        else if (take)
        begin
            if (pop_word[`DDSWD_PDOWN_POS])
                pdown_q <= 1'h1; // RULE6
            else
            begin
                pdown_q <= 1'h0; // RULE6
                speed_q <= pop_word[`DDSWD_SPEED_POS]; // RULE5
            end
        end
    end

    // latches and buffer
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            chan_a_q <= `DDSWD_DATA_RST; // RULE3
            chan_b_q <= `DDSWD_DATA_RST; // RULE3
            buf_q <= `DDSWD_DATA_RST; // RULE3
        end
        else if (take && !pop_word[`DDSWD_PDOWN_POS])
        begin
            case (sel)
                ddswd_pkg::SEL_B_AND_BUF:
                begin
                    chan_b_q <= new_data; // RULE8
                    buf_q <= new_data; // RULE8
                end
                ddswd_pkg::SEL_BUF_ONLY:
                    buf_q <= new_data; // RULE9
                ddswd_pkg::SEL_A_COPY_B:
                begin
                    chan_a_q <= new_data; // RULE10
                    chan_b_q <= buf_q; // RULE16
                end
                ddswd_pkg::SEL_RESERVED:
                    chan_a_q <= chan_a_q; // RULE11
                default:
                    chan_a_q <= chan_a_q;
            endcase
        end
    end

    // bits 1 and 0 are passed through; a host that breaks the zero convention just
    // sees them in the low bits, the ten-bit value above is unaffected
    assign channel_a_output = chan_a_q;
    assign channel_b_output = chan_b_q;
    assign buffer_value = buf_q;
    assign speed_select_bit = speed_q;
    assign power_down_flag = pdown_q;
    assign word_dropped = dropped_q;

    // checks: mode and latch checks look one clock after the word is applied
    // the reset checks run without a disable so that they see the reset itself
    reset_clears_a: assert property (@(posedge clock) // RULE3
        sys_rst |=> chan_a_q == '0 && chan_b_q == '0 && buf_q == '0)
        else $error("latches not cleared by reset");

    reset_modes_a: assert property (@(posedge clock) // RULE7
        sys_rst |=> !speed_q && !pdown_q)
        else $error("mode bits not cleared by reset");

    cs_idle_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE1
        cs_n_s |=> state_q == ddswd_pkg::SH_IDLE && count_q == '0)
        else $error("shifter not idle while deselected");

    sixteen_bits_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
        !cs_n_s && sclk_fall && state_q == ddswd_pkg::SH_SHIFT
        && count_q == `DDSWD_LAST_BIT |=> state_q == ddswd_pkg::SH_DONE)
        else $error("word not complete after sixteen bits");

    shift_msb_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE1
        !cs_n_s && sclk_fall && state_q != ddswd_pkg::SH_DONE
        |=> shift_q[0] == $past(din_s) && shift_q[15:1] == $past(shift_q[14:0]))
        else $error("serial bit not shifted in msb first");

    update_edge_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE14
        state_q == ddswd_pkg::SH_DONE && sclk_rise && !cs_n_s && push_ready
        |-> push_valid ##2 pop_valid)
        else $error("word not handed on at rising edge after bit 0");

    cs_early_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
        cs_rise && state_q == ddswd_pkg::SH_SHIFT && push_ready |-> push_valid ##2 pop_valid)
        else $error("cut word not handed on at deselect");

    drop_flag_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
        push_valid && !push_ready |=> word_dropped)
        else $error("lost word not flagged");

    apply_only_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE14
        !take |=> $stable(chan_a_q) && $stable(chan_b_q) && $stable(buf_q)
        && $stable(speed_q) && $stable(pdown_q))
        else $error("output moved without an applied word");

    power_down_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE6
        take && pop_word[`DDSWD_PDOWN_POS]
        |=> pdown_q && $stable(chan_a_q) && $stable(chan_b_q) && $stable(buf_q)
        && $stable(speed_q))
        else $error("power-down word changed other state");

    speed_set_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE5
        take && !pop_word[`DDSWD_PDOWN_POS]
        |=> speed_q == $past(pop_word[`DDSWD_SPEED_POS]) && !pdown_q)
        else $error("speed bit not applied");

    sel_b_buf_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE8
        take && !pop_word[`DDSWD_PDOWN_POS] && sel == ddswd_pkg::SEL_B_AND_BUF
        |=> chan_b_q == $past(new_data) && buf_q == $past(new_data)
        && $stable(chan_a_q))
        else $error("select 00 did not load channel B and buffer");

    sel_buf_only_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE9
        take && !pop_word[`DDSWD_PDOWN_POS] && sel == ddswd_pkg::SEL_BUF_ONLY
        |=> buf_q == $past(new_data) && $stable(chan_a_q) && $stable(chan_b_q))
        else $error("select 01 touched an output");

    sel_a_copy_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
        take && !pop_word[`DDSWD_PDOWN_POS] && sel == ddswd_pkg::SEL_A_COPY_B
        |=> chan_a_q == $past(new_data) && chan_b_q == $past(buf_q))
        else $error("select 10 did not update both channels together");

    sel_a_buf_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE10
        take && !pop_word[`DDSWD_PDOWN_POS] && sel == ddswd_pkg::SEL_A_COPY_B
        |=> $stable(buf_q))
        else $error("select 10 disturbed the buffer");

    sel_reserved_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE11
        take && sel == ddswd_pkg::SEL_RESERVED
        |=> $stable(chan_a_q) && $stable(chan_b_q) && $stable(buf_q))
        else $error("reserved select changed a latch");

    data_field_a: assert property (@(posedge clock) disable iff (sys_rst) // RULE12
        take && !pop_word[`DDSWD_PDOWN_POS] && sel != ddswd_pkg::SEL_RESERVED
        |=> buf_q == $past(new_data) || chan_a_q == $past(new_data))
        else $error("data field not taken as the new value");
endmodule : ddswd_decoder

// >>> pkg/ddswd_defs.svh
// What this block does
// (RULE1) with chip select low, one bit is shifted in on each falling serial clock edge, MSB first.
// (RULE2) after 16 bits, or when chip select rises early, the word goes to the selected latch.
// (RULE3) reset clears every latch to zero.
// (RULE4) a word is 16 bits: bits 15..12 are program bits, bits 11..0 are the data value.
// (RULE5) bit 14 set selects fast settling, clear selects slow settling.
// (RULE6) bit 13 set powers the converter down whatever the other bits say; clear runs normally.
// (RULE7) reset leaves speed and power-down at zero: slow mode, normal operation.
// (RULE8) select 00 writes the data to channel B and to the intermediate buffer.
// (RULE9) select 01 writes the data to the buffer only, both outputs stay as they are.
// (RULE10) select 10 writes the data to channel A and copies the buffer into channel B.
// (RULE11) select 11 is reserved and changes no latch and not the buffer.
// (RULE12) whenever a latch or the buffer is written from the word, it takes the twelve data bits.
// (RULE13) the host sends bits 1 and 0 as zero, so only ten bits of value are significant.
// (RULE14) the addressed output changes after the rising serial clock edge that follows bit 0.
// (RULE15) the host loads channel B via a buffer-only word, then sends a channel A word.
// (RULE16) that channel A word changes both outputs on the same update.
`ifndef DDSWD_DEFS_SVH
`define DDSWD_DEFS_SVH

`define DDSWD_WORD_BITS 16
`define DDSWD_DATA_BITS 12
`define DDSWD_CNT_BITS 4
`define DDSWD_LAST_BIT 4'hF
`define DDSWD_SEL_HI_POS 15
`define DDSWD_SPEED_POS 14
`define DDSWD_PDOWN_POS 13
`define DDSWD_SEL_LO_POS 12
`define DDSWD_DATA_MSB 11
`define DDSWD_FIFO_DEPTH 16
`define DDSWD_DATA_RST 12'h000
`define DDSWD_SPEED_RST 1'h0
`define DDSWD_PDOWN_RST 1'h0

`endif

// >>> pkg/ddswd_pkg.sv
package ddswd_pkg;
    // shifter progress, gray along idle -> shift -> done
    typedef enum logic [1:0] {
        SH_IDLE = 2'h0,
        SH_SHIFT = 2'h1,
        SH_DONE = 2'h3
    } ddswd_shift_type;

    // latch select code formed from bits 15 and 12
    typedef enum logic [1:0] {
        SEL_B_AND_BUF = 2'h0,
        SEL_BUF_ONLY = 2'h1,
        SEL_A_COPY_B = 2'h2,
        SEL_RESERVED = 2'h3
    } ddswd_sel_type;
endpackage : ddswd_pkg

// >>> rtl/ddswd_sync.sv
// two-flop synchroniser, one stage pair per bit
module ddswd_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_q;
            logic stable_q;
            // first stage feeds only the second
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                begin
                    meta_q <= 1'h1;
                    stable_q <= 1'h1;
                end
                else
                begin
                    meta_q <= async_in[i];
                    stable_q <= meta_q;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate
endmodule : ddswd_sync

// >>> rtl/ddswd_fifo.sv
// word fifo with registered read data; one extra word lives in the output stage
module ddswd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic do_wr;
    logic do_load;

    // full when the memory holds DEPTH words; the output stage holds one more on top
    assign in_ready = count_q != (AW+1)'(DEPTH);
    assign do_wr = in_valid && in_ready;
    // refill the output stage when it is empty or being taken
    assign do_load = (count_q != '0) && (!out_valid_q || out_ready);
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    // storage write
    always_ff @(posedge clock)
    begin
        if (do_wr)
            mem_q[wr_ptr_q] <= in_data;
    end

    // pointers and fill level
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr_q <= wr_ptr_q + 1'h1;
            if (do_load)
                rd_ptr_q <= rd_ptr_q + 1'h1;
            count_q <= count_q + (AW+1)'(do_wr) - (AW+1)'(do_load);
        end
    end

    // output register
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            out_valid_q <= 1'h0;
            out_data_q <= '0;
        end
        else if (do_load)
        begin
            out_valid_q <= 1'h1;
            out_data_q <= mem_q[rd_ptr_q];
        end
        else if (out_ready)
            out_valid_q <= 1'h0;
    end
endmodule : ddswd_fifo

// >>> dv/ddswd_host_model.sv
// host side of the three-wire link; serial clock idles high and stands still between frames
module ddswd_host_model (
    input wire logic clock,
    output logic chip_select_n,
    output logic serial_clock,
    output logic serial_data
);
    timeunit 1ns;
    timeprecision 1ps;

    realtime last_rise;

    initial
    begin
        chip_select_n = 1'h1;
        serial_clock = 1'h1;
        serial_data = 1'h0;
        last_rise = 0;
    end

    // n bits of w, msb first; keep leaves chip select low for a following word
    task automatic send_word(input logic [15:0] w, input int n, input bit keep);
        @(negedge clock);
        chip_select_n = 1'h0;
        #40;
        for (int i = 0; i < n; i++)
        begin
            serial_data = w[15-i];
            #40;
            serial_clock = 1'h0;
            #80;
            serial_clock = 1'h1;
            last_rise = $realtime;
            #40;
        end
        if (!keep)
        begin
            chip_select_n = 1'h1;
            // released line must not keep looking like valid data
            serial_data = ~serial_data;
        end
    endtask : send_word
endmodule : ddswd_host_model

// >>> dv/tb_dual_dac_serial_word_decoder.sv
module tb_dual_dac_serial_word_decoder;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [11:0] a;
        logic [11:0] b;
        logic [11:0] f;
        logic s;
        logic p;
    } ddswd_state_type;

    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic update_hold = 1'h0;
    logic chip_select_n;
    logic serial_clock;
    logic serial_data;
    logic [11:0] ch_a;
    logic [11:0] ch_b;
    logic [11:0] buf_v;
    logic fast_v;
    logic pdf;
    logic drop;
    int failures = 0;
    int n_compared = 0;
    int n_drops = 0;
    int cycles = 0;
    bit check_lat = 0;
    logic [31:0] seed = 32'h0000003A;
    logic [15:0] sh = 16'h0000;
    ddswd_state_type q[$];
    ddswd_state_type model_s = '0;
    ddswd_state_type seen_s = '0;
    ddswd_state_type exp_s;
    logic [31:0] r;
    realtime dt;

    always #5 clock = ~clock;

    ddswd_host_model host (
        .clock(clock),
        .chip_select_n(chip_select_n),
        .serial_clock(serial_clock),
        .serial_data(serial_data)
    );

    // small fifo so the refusal case is reached quickly
    ddswd_decoder #(.FIFO_DEPTH(4)) DUT (
        .clock(clock),
        .sys_rst(sys_rst),
        .chip_select_n(chip_select_n),
        .serial_clock(serial_clock),
        .serial_data(serial_data),
        .update_hold(update_hold),
        .channel_a_output(ch_a),
        .channel_b_output(ch_b),
        .buffer_value(buf_v),
        .speed_select_bit(fast_v),
        .power_down_flag(pdf),
        .word_dropped(drop)
    );

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // note the expected latch state, then send; a cut word keeps older bits above the new ones
    task automatic send(input logic [15:0] w, input int n, input bit keep);
        logic [15:0] v;
        ddswd_state_type nx;
        sh = (sh << n) | (w >> (16 - n));
        v = sh;
        nx = model_s;
        if (v[13])
            nx.p = 1'h1;
        else
        begin
            nx.p = 1'h0;
            nx.s = v[14];
            case ({v[15], v[12]})
                2'h0:
                begin
                    nx.b = v[11:0];
                    nx.f = v[11:0];
                end
                2'h1: nx.f = v[11:0];
                2'h2:
                begin
                    nx.a = v[11:0];
                    nx.b = model_s.f;
                end
                default: ;
            endcase
        end
        if (nx !== model_s)
            q.push_back(nx);
        model_s = nx;
        host.send_word(w, n, keep);
    endtask : send

    // outputs must move together, once per applied word, in the order sent
    always @(negedge clock)
    begin
        if (!sys_rst)
        begin
            if (drop === 1'h1)
                n_drops++;
            if ({ch_a, ch_b, buf_v, fast_v, pdf} !== seen_s)
            begin
                seen_s = {ch_a, ch_b, buf_v, fast_v, pdf};
                check(64'(q.size() != 0), 64'h1);
                if (q.size() != 0)
                begin
                    exp_s = q.pop_front();
                    check(64'(seen_s), 64'(exp_s));
                end
                dt = $realtime - host.last_rise;
                if (check_lat)
                    check(64'(dt >= 30 && dt <= 70), 64'h1);
            end
        end
    end

    // a hang ends the run as a failure
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (5) @(negedge clock);
        sys_rst = 1'h0;
        check(64'({ch_a, ch_b, buf_v, fast_v, pdf}), 64'h0);
        repeat (4) @(negedge clock);
        check_lat = 1;
        // every select code at both speeds, back to back under one chip select
        for (int k = 0; k < 8; k++)
        begin
            r = xorshift();
            send({k[1], k[2], 1'h0, k[0], r[11:4], 4'h0}, 16, k < 7);
        end
        r = xorshift();
        send({r[15:14], 1'h1, r[12:4], 4'h0}, 16, 0);
        send({4'h4, r[23:16], 4'h0}, 16, 0);
        check_lat = 0;
        r = xorshift();
        send({r[15:6], 6'h00}, 12, 0);
        repeat (10) @(negedge clock);
        // hold the drain: five words queue, the sixth is refused
        update_hold = 1'h1;
        for (int k = 0; k < 5; k++)
            send({4'h1, 8'(k + 1), 4'h0}, 16, 0);
        host.send_word(16'h1FF0, 16, 0);
        repeat (10) @(negedge clock);
        check(64'(n_drops), 64'h1);
        check(64'(q.size()), 64'h5);
        update_hold = 1'h0;
        repeat (20) @(negedge clock);
        check(64'(q.size()), 64'h0);
        end_of_test();
    end
endmodule : tb_dual_dac_serial_word_decoder
